// File: core/rfpi_core.sv
// paged inventory read and surveillance arm/disarm command handler
`timescale 1ns/10ps
`include "rfpi_defines.svh"
module rfpi_core (
	// clock and reset
	input  wire logic                   clk_i,
	input  wire logic                   rst_n_i,
	// received frame from the air decoder
	input  wire logic                   rx_valid_i,
	input  wire logic                   rx_first_i,
	input  wire logic [7:0]             rx_byte_i,
	input  wire logic                   rx_eof_i,
	input  wire logic                   rx_err_i,
	input  wire logic                   slot_next_i,
	// tag identity and configuration
	input  wire logic [63:0]            uid_i,
	input  wire logic [7:0]             afi_i,
	input  wire logic [`RFPI_PAGES-1:0] page_prot_i,
	input  wire logic                   read_pw_ok_i,
	input  wire logic                   surv_locked_i,
	input  wire logic                   surv_pw_prot_i,
	input  wire logic                   surv_pw_ok_i,
	// page memory
	input  wire logic [7:0]             mem_byte_i,
	output logic [7:0]                  mem_page_o,
	output logic [3:0]                  mem_idx_o,
	// reply stream to the air encoder
	input  wire logic                   tx_ready_i,
	output logic                        tx_valid_o,
	output logic                        tx_last_o,
	output logic [7:0]                  tx_byte_o,
	output logic                        tx_fast_o,
	output logic                        tx_hi_rate_o,
	output logic                        tx_dual_o,
	output logic                        tx_write_timing_o,
	// surveillance state
	output logic                        surv_mode_o
);
	// ***************************************************************
	// state and decoding
	// ***************************************************************
	rfpi_pkg::rfpi_state_t state_r;
	logic [7:0]  flags_r;
	logic [7:0]  cmd_r;
	logic [7:0]  mlen_r;
	logic [63:0] mask_r;
	logic [7:0]  pg_r;
	logic [7:0]  npg_r;
	logic [3:0]  idx_r;
	logic [3:0]  slot_r;
	logic        uid_ok_r;
	logic        afi_miss_r;
	logic        err_r;
	logic        surv_mode_r;
	logic        tx_valid_r;
	logic        tx_last_r;
	logic [7:0]  tx_byte_r;
	logic [3:0]  tx_mode_r;

	wire logic       is_inv    = (cmd_r == `RFPI_CMD_PAGE_INV) | (cmd_r == `RFPI_CMD_FAST_INV);
	wire logic       is_fast   = (cmd_r == `RFPI_CMD_FAST_INV);
	wire logic       is_surv   = (cmd_r == `RFPI_CMD_SURV_ARM) | (cmd_r == `RFPI_CMD_SURV_DIS);
	wire logic       f_inv     = flags_r[`RFPI_F_INV];
	wire logic       f_addr    = flags_r[`RFPI_F_ADDR];
	wire logic       f_opt     = flags_r[`RFPI_F_OPT];
	wire logic       slot16    = ~flags_r[`RFPI_F_ONE_SLOT];
	wire logic [7:0] mlen_up   = mlen_r + `RFPI_ROUND_UP;
	wire logic [3:0] uid_first = mlen_up[6:3];
	wire logic [7:0] mask_max  = slot16 ? `RFPI_MASK_MAX_16 : `RFPI_MASK_MAX_1;
	wire logic [7:0] uid_sel   = uid_i[{idx_r[2:0], 3'b000} +: 8];
	wire logic       stat_prot = page_prot_i[pg_r[`RFPI_PG_W-1:0]] & ~read_pw_ok_i;
	wire logic       page_done = (npg_r == 8'h00) | (pg_r == `RFPI_LAST_PAGE);
	wire logic       ld        = ~tx_valid_r | tx_ready_i;
	wire logic       new_frame = rx_valid_i & rx_first_i;
	wire logic       in_rx     = state_r inside {rfpi_pkg::st_cmd, rfpi_pkg::st_mfg,
		rfpi_pkg::st_uid, rfpi_pkg::st_afi, rfpi_pkg::st_mlen, rfpi_pkg::st_mask,
		rfpi_pkg::st_fpg, rfpi_pkg::st_npg, rfpi_pkg::st_end};
	wire logic       eof_ok    = rx_eof_i & ~rx_err_i & (state_r == rfpi_pkg::st_end);
	wire logic       addr_ok   = ~f_addr | uid_ok_r;
	wire logic       surv_deny = surv_locked_i | (surv_pw_prot_i & ~surv_pw_ok_i);
	wire logic       surv_go   = is_surv & ~f_inv & addr_ok;
	wire logic       unsup_err = ~is_inv & ~is_surv & f_addr & uid_ok_r & ~f_inv &
		~flags_r[`RFPI_F_EXT];
	wire logic       hit;

	// ***************************************************************
	// mask and slot compare
	// ***************************************************************
	rfpi_match_if mif ();
	assign mif.uid    = uid_i;
	assign mif.mask   = mask_r;
	assign mif.mlen   = mlen_r;
	assign mif.slot   = slot_r;
	assign mif.slot16 = slot16;
	assign hit        = mif.hit;

	rfpi_mask_match u_match (
		.m (mif)
	);

	// ***************************************************************
	// request parse, execution and reply sequencing
	// ***************************************************************
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r      <= rfpi_pkg::st_idle;
			flags_r      <= 8'h00;
			cmd_r        <= 8'h00;
			mlen_r       <= 8'h00;
			mask_r       <= 64'h0;
			pg_r         <= 8'h00;
			npg_r        <= 8'h00;
			idx_r        <= 4'h0;
			slot_r       <= 4'h0;
			uid_ok_r     <= 1'b0;
			afi_miss_r   <= 1'b0;
			err_r        <= 1'b0;
			surv_mode_r  <= 1'b0;
			tx_valid_r   <= 1'b0;
			tx_last_r    <= 1'b0;
			tx_byte_r    <= 8'h00;
			tx_mode_r    <= 4'h0;
		end else begin
			if (ld)
				tx_valid_r <= 1'b0;
			// a new frame always restarts parsing, even mid-slot
			if (new_frame) begin
				flags_r    <= rx_byte_i;
				state_r    <= rfpi_pkg::st_cmd;
				uid_ok_r   <= 1'b1;
				afi_miss_r <= 1'b0;
				idx_r      <= 4'h0;
				slot_r     <= 4'h0;
			end else if (rx_eof_i && in_rx) begin
				if (!eof_ok) begin
					state_r <= rfpi_pkg::st_idle;
				end else begin
					tx_mode_r    <= {is_fast, flags_r[`RFPI_F_RATE],
						flags_r[`RFPI_F_SUBC] & ~is_fast, ~is_inv};
					err_r        <= (surv_go & surv_deny) | unsup_err;
					if (is_inv)
						state_r <= rfpi_pkg::st_slot;
					else if (surv_go || unsup_err)
						state_r <= rfpi_pkg::st_tflg;
					else
						state_r <= rfpi_pkg::st_idle;
					// lock freezes the mode; set and clear both refused
					if (surv_go && !surv_deny)
						surv_mode_r <= (cmd_r == `RFPI_CMD_SURV_ARM);
				end
			end else if (rx_valid_i || !in_rx) begin
				// request states only move on a received byte
				case (state_r)
					rfpi_pkg::st_cmd: begin
						cmd_r   <= rx_byte_i;
						state_r <= rfpi_pkg::st_mfg;
					end
					rfpi_pkg::st_mfg: begin
						if (rx_byte_i != `RFPI_MFG_CODE)
							state_r <= rfpi_pkg::st_idle;
						else if (is_inv && (!f_inv || flags_r[`RFPI_F_RFU]))
							state_r <= rfpi_pkg::st_idle;
						else if (is_inv && flags_r[`RFPI_F_AFI])
							state_r <= rfpi_pkg::st_afi;
						else if (is_inv)
							state_r <= rfpi_pkg::st_mlen;
						else if (f_addr)
							state_r <= rfpi_pkg::st_uid;
						else
							state_r <= rfpi_pkg::st_end;
					end
					rfpi_pkg::st_uid: begin
						if (rx_byte_i != uid_sel)
							uid_ok_r <= 1'b0;
						idx_r <= idx_r + 4'h1;
						if (idx_r == `RFPI_LAST_UID)
							state_r <= rfpi_pkg::st_end;
					end
					rfpi_pkg::st_afi: begin
						// zero selects every family
						afi_miss_r <= (rx_byte_i != 8'h00) && (rx_byte_i != afi_i);
						state_r    <= rfpi_pkg::st_mlen;
					end
					rfpi_pkg::st_mlen: begin
						mlen_r <= rx_byte_i;
						mask_r <= 64'h0;
						idx_r  <= 4'h0;
						if (rx_byte_i > mask_max)
							state_r <= rfpi_pkg::st_idle;
						else if (rx_byte_i == 8'h00)
							state_r <= rfpi_pkg::st_fpg;
						else
							state_r <= rfpi_pkg::st_mask;
					end
					rfpi_pkg::st_mask: begin
						mask_r[{idx_r[2:0], 3'b000} +: 8] <= rx_byte_i;
						idx_r <= idx_r + 4'h1;
						if (idx_r == uid_first - 4'h1)
							state_r <= rfpi_pkg::st_fpg;
					end
					rfpi_pkg::st_fpg: begin
						pg_r    <= rx_byte_i;
						state_r <= (rx_byte_i > `RFPI_LAST_PAGE) ? rfpi_pkg::st_idle :
							rfpi_pkg::st_npg;
					end
					rfpi_pkg::st_npg: begin
						npg_r   <= rx_byte_i;
						state_r <= rfpi_pkg::st_end;
					end
					rfpi_pkg::st_end: begin
						// surplus bytes only matter for commands we understand
						if (is_inv || is_surv)
							state_r <= rfpi_pkg::st_idle;
					end
					rfpi_pkg::st_slot: begin
						if (afi_miss_r)
							state_r <= rfpi_pkg::st_idle;
						else if (hit)
							state_r <= rfpi_pkg::st_tflg;
						else if (!slot16)
							state_r <= rfpi_pkg::st_idle;
						else if (slot_next_i) begin
							slot_r  <= slot_r + 4'h1;
							state_r <= (slot_r == `RFPI_LAST_SLOT) ? rfpi_pkg::st_idle :
								rfpi_pkg::st_slot;
						end
					end
					rfpi_pkg::st_tflg: begin
						if (ld) begin
							tx_valid_r <= 1'b1;
							tx_byte_r  <= err_r ? `RFPI_RESP_ERR : `RFPI_RESP_OK;
							tx_last_r  <= ~err_r & is_surv;
							idx_r      <= f_opt ? uid_first : 4'h0;
							if (err_r)
								state_r <= rfpi_pkg::st_terr;
							else if (is_surv)
								state_r <= rfpi_pkg::st_idle;
							else if (f_opt && uid_first != `RFPI_UID_BYTES)
								state_r <= rfpi_pkg::st_tuid;
							else
								state_r <= rfpi_pkg::st_tstat;
						end
					end
					rfpi_pkg::st_terr: begin
						if (ld) begin
							tx_valid_r <= 1'b1;
							tx_byte_r  <= `RFPI_ERR_GENERIC;
							tx_last_r  <= 1'b1;
							state_r    <= rfpi_pkg::st_idle;
						end
					end
					rfpi_pkg::st_tuid: begin
						if (ld) begin
							// whole bytes of the real identifier, slot bits included only when the mask length is a multiple of 8
							tx_valid_r <= 1'b1;
							tx_byte_r  <= uid_sel;
							tx_last_r  <= 1'b0;
							idx_r      <= (idx_r == `RFPI_LAST_UID) ? 4'h0 : idx_r + 4'h1;
							if (idx_r == `RFPI_LAST_UID)
								state_r <= rfpi_pkg::st_tstat;
						end
					end
					rfpi_pkg::st_tstat: begin
						if (ld) begin
							tx_valid_r <= 1'b1;
							tx_byte_r  <= stat_prot ? `RFPI_ST_PROT : `RFPI_ST_OPEN;
							tx_last_r  <= stat_prot & page_done;
							idx_r      <= 4'h0;
							if (!stat_prot)
								state_r <= rfpi_pkg::st_tdata;
							else if (page_done)
								state_r <= rfpi_pkg::st_idle;
							else begin
								pg_r  <= pg_r + 8'h01;
								npg_r <= npg_r - 8'h01;
							end
						end
					end
					rfpi_pkg::st_tdata: begin
						if (ld) begin
							tx_valid_r <= 1'b1;
							tx_byte_r  <= mem_byte_i;
							tx_last_r  <= (idx_r == `RFPI_LAST_DATA) & page_done;
							idx_r      <= idx_r + 4'h1;
							if (idx_r == `RFPI_LAST_DATA) begin
								pg_r    <= pg_r + 8'h01;
								npg_r   <= npg_r - 8'h01;
								state_r <= page_done ? rfpi_pkg::st_idle :
									rfpi_pkg::st_tstat;
							end
						end
					end
					default: begin
						state_r <= rfpi_pkg::st_idle;
					end
				endcase
			end
		end
	end

	assign mem_page_o        = pg_r;
	assign mem_idx_o         = idx_r;
	assign tx_valid_o        = tx_valid_r;
	assign tx_last_o         = tx_last_r;
	assign tx_byte_o         = tx_byte_r;
	assign {tx_fast_o, tx_hi_rate_o, tx_dual_o, tx_write_timing_o} = tx_mode_r;
	assign surv_mode_o       = surv_mode_r;

	// ***************************************************************
	// checks
	// ***************************************************************
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	bad_frame_silent_a: assert property (
		(rx_eof_i && rx_err_i && in_rx && !new_frame) |=> state_r == rfpi_pkg::st_idle ##1
		!tx_valid_o) else $error("reply started after a bad frame");
	page_status_a: assert property (
		(state_r == rfpi_pkg::st_tstat && ld) |=>
		tx_byte_o == ($past(stat_prot) ? `RFPI_ST_PROT : `RFPI_ST_OPEN))
		else $error("wrong page status byte");
	prot_no_data_a: assert property (
		(state_r == rfpi_pkg::st_tstat && ld && stat_prot) |=>
		state_r != rfpi_pkg::st_tdata) else $error("data sent for protected page");
	fast_single_a: assert property (
		tx_fast_o |-> !tx_dual_o) else $error("dual subcarrier on fast reply");
	lock_freeze_a: assert property (
		surv_locked_i |=> surv_mode_o == $past(surv_mode_o))
		else $error("surveillance mode changed while locked");
	err_code_a: assert property (
		(state_r == rfpi_pkg::st_terr && ld) |=> tx_byte_o == `RFPI_ERR_GENERIC && tx_last_o)
		else $error("error code byte wrong");
	last_page_a: assert property (
		(state_r == rfpi_pkg::st_tdata && ld && idx_r == `RFPI_LAST_DATA) |=>
		tx_last_o == $past(page_done)) else $error("page run ended at wrong page");
	no_uid_opt0_a: assert property (
		(state_r == rfpi_pkg::st_tflg && ld && is_inv && !err_r && !f_opt) |=>
		state_r == rfpi_pkg::st_tstat) else $error("identifier sent with option clear");
	surv_ok_a: assert property (
		(state_r == rfpi_pkg::st_tflg && ld && is_surv && !err_r) |=>
		tx_last_o && tx_byte_o == `RFPI_RESP_OK) else $error("arm reply not flags only");
endmodule // rfpi_core

// File: core/rfpi_mask_match.sv
// identifier mask compare with slot number check
`timescale 1ns/10ps
module rfpi_mask_match (
	// comparison operands and result
	rfpi_match_if.cmp m
);
	logic [63:0] bit_ok;
	logic [63:0] uid_shift;
	logic        slot_ok;

	genvar i;
	for (i = 0; i < 64; i++) begin : g_bit
		assign bit_ok[i] = (m.mlen <= 8'(i)) | (m.mask[i] == m.uid[i]);
	end

	// the slot number sits in the four identifier bits above the mask
	assign uid_shift = m.uid >> m.mlen;
	assign slot_ok   = ~m.slot16 | (uid_shift[3:0] == m.slot);
	assign m.hit     = (&bit_ok) & slot_ok;
endmodule // rfpi_mask_match

// File: inc/rfpi_defines.svh
// constants of the paged inventory and surveillance command block
`ifndef RFPI_DEFINES_SVH
`define RFPI_DEFINES_SVH
// ***************************************************************
// command codes and identity
// ***************************************************************
`define RFPI_CMD_PAGE_INV 8'hb0
`define RFPI_CMD_FAST_INV 8'hb1
`define RFPI_CMD_SURV_ARM 8'ha2
`define RFPI_CMD_SURV_DIS 8'ha3
// arbitrary value, not a real maker code
`define RFPI_MFG_CODE 8'h5a
// ***************************************************************
// response bytes
// ***************************************************************
`define RFPI_RESP_OK 8'h00
`define RFPI_RESP_ERR 8'h01
`define RFPI_ERR_GENERIC 8'h0f
`define RFPI_ST_OPEN 8'h00
`define RFPI_ST_PROT 8'h0f
// ***************************************************************
// request flag bit positions
// ***************************************************************
`define RFPI_F_SUBC 0
`define RFPI_F_RATE 1
`define RFPI_F_INV 2
`define RFPI_F_EXT 3
`define RFPI_F_AFI 4
`define RFPI_F_ONE_SLOT 5
`define RFPI_F_ADDR 5
`define RFPI_F_OPT 6
`define RFPI_F_RFU 7
// ***************************************************************
// sizes and limits
// ***************************************************************
`define RFPI_PAGES 8
`define RFPI_PG_W 3
`define RFPI_LAST_PAGE 8'h07
`define RFPI_LAST_DATA 4'hf
`define RFPI_LAST_UID 4'h7
`define RFPI_UID_BYTES 4'h8
`define RFPI_LAST_SLOT 4'hf
`define RFPI_MASK_MAX_1 8'h40
`define RFPI_MASK_MAX_16 8'h3c
`define RFPI_ROUND_UP 8'h07
`endif

// File: inc/rfpi_match_if.sv
// identifier mask and slot comparison signals
`timescale 1ns/10ps
interface rfpi_match_if;
	logic [63:0] uid;
	logic [63:0] mask;
	logic [7:0]  mlen;
	logic [3:0]  slot;
	logic        slot16;
	logic        hit;
	modport ctl (output uid, mask, mlen, slot, slot16, input hit);
	modport cmp (input uid, mask, mlen, slot, slot16, output hit);
endinterface

// File: inc/rfpi_pkg.sv
// types of the paged inventory and surveillance command block
package rfpi_pkg;
	typedef enum logic [15:0] {
		st_idle  = 16'h0001,
		st_cmd   = 16'h0002,
		st_mfg   = 16'h0004,
		st_uid   = 16'h0008,
		st_afi   = 16'h0010,
		st_mlen  = 16'h0020,
		st_mask  = 16'h0040,
		st_fpg   = 16'h0080,
		st_npg   = 16'h0100,
		st_end   = 16'h0200,
		st_slot  = 16'h0400,
		st_tflg  = 16'h0800,
		st_terr  = 16'h1000,
		st_tuid  = 16'h2000,
		st_tstat = 16'h4000,
		st_tdata = 16'h8000
	} rfpi_state_t;
endpackage

// File: verif/rfpi_reader_model.sv
// reader-side model: sends request frames, collects the reply stream
`timescale 1ns/10ps
module rfpi_reader_model (
	// clock and stall control
	input  wire logic       clk_i,
	input  wire logic       stall_i,
	// reply stream from the tag
	input  wire logic       tx_valid_i,
	input  wire logic       tx_last_i,
	input  wire logic [7:0] tx_byte_i,
	output logic            tx_ready_o,
	// request stream to the tag
	output logic            rx_valid_o,
	output logic            rx_first_o,
	output logic [7:0]      rx_byte_o,
	output logic            rx_eof_o,
	output logic            rx_err_o,
	output logic            slot_next_o
);
	logic [7:0] reply_q[$];
	logic       done;

	initial begin
		{rx_valid_o, rx_first_o, rx_eof_o, rx_err_o, slot_next_o} = 5'h00;
		rx_byte_o = 8'h00;
		tx_ready_o = 1'b1;
		done = 1'b0;
	end

	// fields go out in the order the caller built them, crc already stripped
	task automatic send(input logic [7:0] f[$], input logic err);
		int i;
		reply_q.delete();
		done = 1'b0;
		for (i = 0; i < f.size(); i++) begin
			@(negedge clk_i);
			rx_valid_o = 1'b1;
			rx_first_o = (i == 0);
			rx_byte_o = f[i];
		end
		@(negedge clk_i);
		rx_valid_o = 1'b0;
		rx_first_o = 1'b0;
		// released data line must not keep looking valid
		rx_byte_o = ~rx_byte_o;
		rx_eof_o = 1'b1;
		rx_err_o = err;
		@(negedge clk_i);
		rx_eof_o = 1'b0;
		rx_err_o = 1'b0;
	endtask

	task automatic next_slot();
		@(negedge clk_i);
		slot_next_o = 1'b1;
		@(negedge clk_i);
		slot_next_o = 1'b0;
	endtask

	// stalling reader takes a byte only every other cycle
	always @(negedge clk_i) tx_ready_o <= stall_i ? ~tx_ready_o : 1'b1;

	always @(posedge clk_i) begin
		if (tx_valid_i && tx_ready_o) begin
			reply_q.push_back(tx_byte_i);
			if (tx_last_i)
				done <= 1'b1;
		end
	end
endmodule // rfpi_reader_model

// File: verif/tb_top.sv
// self-checking testbench of the paged inventory and surveillance block
`timescale 1ns/10ps
`include "rfpi_defines.svh"
module tb_top;
	typedef logic [7:0] rfpi_bq_t[$];
	logic clk, rst_n, stall, pw, locked, pprot, pok;
	logic [63:0] uid;
	logic [7:0] afi, prot, mpage, mbyte, txb, rxb;
	logic [3:0] midx;
	logic rxv, rxf, rxe, rxr, slot, txr, txv, txl, fast, hi, dual, wt, surv;
	logic cfast, chi, cdual, cwt;
	int error_cnt = 0;
	int cmp_count = 0;

	// ***************************************************************
	// clock, memory and instances
	// ***************************************************************
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	assign mbyte = {mpage[3:0], midx};
	always @(posedge clk) if (txv && txr) {cfast, chi, cdual, cwt} <= {fast, hi, dual, wt};

	rfpi_reader_model rm (.clk_i(clk), .stall_i(stall), .tx_valid_i(txv), .tx_last_i(txl),
		.tx_byte_i(txb), .tx_ready_o(txr), .rx_valid_o(rxv), .rx_first_o(rxf),
		.rx_byte_o(rxb), .rx_eof_o(rxe), .rx_err_o(rxr), .slot_next_o(slot));
	rfpi_core uut (.clk_i(clk), .rst_n_i(rst_n), .rx_valid_i(rxv), .rx_first_i(rxf),
		.rx_byte_i(rxb), .rx_eof_i(rxe), .rx_err_i(rxr), .slot_next_i(slot),
		.uid_i(uid), .afi_i(afi), .page_prot_i(prot), .read_pw_ok_i(pw),
		.surv_locked_i(locked), .surv_pw_prot_i(pprot), .surv_pw_ok_i(pok),
		.mem_byte_i(mbyte), .mem_page_o(mpage), .mem_idx_o(midx), .tx_ready_i(txr),
		.tx_valid_o(txv), .tx_last_o(txl), .tx_byte_o(txb), .tx_fast_o(fast),
		.tx_hi_rate_o(hi), .tx_dual_o(dual), .tx_write_timing_o(wt), .surv_mode_o(surv));

	// ***************************************************************
	// shared tasks
	// ***************************************************************
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic add_uid(inout rfpi_bq_t q, input int first);
		int k;
		for (k = first; k < 8; k++) q.push_back(uid[8*k+:8]);
	endtask

	// status then data, protected pages alone, nothing past the last page
	task automatic add_pages(inout rfpi_bq_t q, input int first, input int cnt);
		int p, i;
		for (p = first; p <= first + cnt && p <= 7; p++) begin
			if (prot[p] && !pw) begin
				q.push_back(`RFPI_ST_PROT);
			end else begin
				q.push_back(`RFPI_ST_OPEN);
				for (i = 0; i < 16; i++) q.push_back({p[3:0], i[3:0]});
			end
		end
	endtask

	// an empty expectation means the tag stays silent
	task automatic run(input rfpi_bq_t f, input logic err, input rfpi_bq_t exp, input int slots);
		int n, i;
		rm.send(f, err);
		for (i = 0; i < slots; i++) begin
			repeat (20) @(negedge clk);
			check(16'(rm.reply_q.size()), 16'h0000);
			rm.next_slot();
		end
		n = 0;
		while (!rm.done && n < 400) begin
			@(negedge clk);
			n++;
		end
		if (exp.size() == 0) begin
			check(16'(rm.reply_q.size()), 16'h0000);
		end else if (n == 400) begin
			error_cnt++;
			$display("MISMATCH t=%0t reply never ended", $time);
			stop_test();
		end else begin
			check(16'(rm.reply_q.size()), 16'(exp.size()));
			for (i = 0; i < exp.size() && i < rm.reply_q.size(); i++)
				check({8'h00, rm.reply_q[i]}, {8'h00, exp[i]});
		end
		repeat (4) @(negedge clk);
	endtask

	// ***************************************************************
	// scenarios
	// ***************************************************************
	task automatic s_surv();
		rfpi_bq_t f;
		rfpi_bq_t ok = '{8'h00};
		rfpi_bq_t bad = '{8'h01, 8'h0f};
		run('{8'h02, `RFPI_CMD_SURV_ARM, `RFPI_MFG_CODE}, 1'b0, ok, 0);
		check(surv, 1);
		check(cwt, 1);
		run('{8'h42, `RFPI_CMD_SURV_DIS, `RFPI_MFG_CODE}, 1'b0, ok, 0);
		check(surv, 0);
		f = '{8'h22, `RFPI_CMD_SURV_ARM, `RFPI_MFG_CODE};
		add_uid(f, 0);
		run(f, 1'b0, ok, 0);
		check(surv, 1);
		locked = 1'b1;
		run('{8'h02, `RFPI_CMD_SURV_DIS, `RFPI_MFG_CODE}, 1'b0, bad, 0);
		check(surv, 1);
		locked = 1'b0;
		pprot = 1'b1;
		run('{8'h02, `RFPI_CMD_SURV_DIS, `RFPI_MFG_CODE}, 1'b0, bad, 0);
		check(surv, 1);
		pok = 1'b1;
		run('{8'h02, `RFPI_CMD_SURV_DIS, `RFPI_MFG_CODE}, 1'b0, ok, 0);
		check(surv, 0);
		{pprot, pok} = 2'b00;
	endtask

	task automatic s_inv();
		rfpi_bq_t e = '{8'h00};
		stall = 1'b1;
		add_pages(e, 6, 3);
		// flags 35: dual subcarrier, low rate, afi, one slot; count 3 runs past page 7
		run('{8'h35, `RFPI_CMD_PAGE_INV, `RFPI_MFG_CODE, 8'h11, 8'h00, 8'h06, 8'h03}, 1'b0,
			e, 0);
		check({cfast, chi, cdual, cwt}, 4'b0010);
		stall = 1'b0;
		pw = 1'b1;
		e = '{8'h00};
		add_uid(e, 2);
		add_pages(e, 7, 0);
		// 12-bit mask rounds up to two bytes, six identifier bytes return
		run('{8'h66, `RFPI_CMD_PAGE_INV, `RFPI_MFG_CODE, 8'h0c, 8'h12, 8'h02, 8'h07, 8'h00}, 1'b0,
			e, 0);
		pw = 1'b0;
	endtask

	task automatic s_fast_slots();
		rfpi_bq_t e = '{8'h00};
		add_pages(e, 0, 0);
		run('{8'h27, `RFPI_CMD_FAST_INV, `RFPI_MFG_CODE, 8'h00, 8'h00, 8'h00}, 1'b0, e, 0);
		check({cfast, chi, cdual}, 3'b110);
		e = '{8'h00};
		add_uid(e, 0);
		add_pages(e, 1, 0);
		// identifier low nibble is 2: answer only in the third slot
		run('{8'h46, `RFPI_CMD_PAGE_INV, `RFPI_MFG_CODE, 8'h00, 8'h01, 8'h00}, 1'b0, e, 2);
	endtask

	task automatic s_err();
		rfpi_bq_t f;
		rfpi_bq_t none;
		run('{8'h02, `RFPI_CMD_SURV_ARM, `RFPI_MFG_CODE}, 1'b1, none, 0);
		run('{8'h26, `RFPI_CMD_PAGE_INV, 8'h5b, 8'h00, 8'h00, 8'h00}, 1'b0, none, 0);
		run('{8'h26, `RFPI_CMD_PAGE_INV, `RFPI_MFG_CODE, 8'h00, 8'h08, 8'h00}, 1'b0, none, 0);
		run('{8'h22, `RFPI_CMD_PAGE_INV, `RFPI_MFG_CODE, 8'h00, 8'h00, 8'h00}, 1'b0, none, 0);
		run('{8'h26, `RFPI_CMD_PAGE_INV, `RFPI_MFG_CODE, 8'h41, 8'h00, 8'h00}, 1'b0, none, 0);
		run('{8'h36, `RFPI_CMD_PAGE_INV, `RFPI_MFG_CODE, 8'h12, 8'h00, 8'h00, 8'h00}, 1'b0, none, 0);
		run('{8'h02, 8'ha9, `RFPI_MFG_CODE}, 1'b0, none, 0);
		f = '{8'h22, 8'ha9, `RFPI_MFG_CODE};
		add_uid(f, 0);
		run(f, 1'b0, '{8'h01, `RFPI_ERR_GENERIC}, 0);
	endtask

	// ***************************************************************
	// main sequence
	// ***************************************************************
	initial begin
		{rst_n, stall, pw, locked, pprot, pok} = 6'h00;
		uid = 64'h8877665544332212;
		afi = 8'h11;
		prot = 8'h81;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		check(surv, 0);
		s_surv();
		s_inv();
		s_fast_slots();
		s_err();
		stop_test();
	end
endmodule // tb_top
